// ===== logic/tas_pkg.sv
// package: constants and types for the tracking converter sequencer
package tas_pkg;
  localparam int unsigned CODE_W       = 10;
  localparam int unsigned FULL_SCALE   = 1024;
  localparam int unsigned EDGE_LIMIT   = 3;
  localparam int unsigned EDGE_W       = 2;
  localparam int unsigned CLK_HZ       = 125000000;
  localparam int unsigned STEP_MAX_HZ  = 1000;
  localparam int unsigned STEP_PERIOD_CYC = (CLK_HZ + STEP_MAX_HZ - 1) / STEP_MAX_HZ;
  localparam int unsigned STEPS_MAX    = 512 + 5;
  localparam logic [9:0]  CODE_RESET   = 10'h200;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LOAD,
    ST_TRACK,
    ST_DONE
  } tas_state_t;

  typedef struct packed {
    logic [9:0] code;
    logic       done;
    logic       busy;
  } tas_result_t;
endpackage : tas_pkg

// ===== logic/tas_step_timer.sv
// module: step tick generator for the wiper clock
`timescale 1ns/10ps
module tas_step_timer #(
  parameter int unsigned PERIOD_CYC = tas_pkg::STEP_PERIOD_CYC
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic run,
  output logic      tick
);
  if (PERIOD_CYC < 2) begin : g_period_check
    $error("period too short");
  end

  logic [31:0] cnt_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 32'h0;
    end else if (!run || cnt_q == PERIOD_CYC - 1) begin
      cnt_q <= 32'h0;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end

  // tick on last count, so first step comes one full period after start
  assign tick = run && (cnt_q == PERIOD_CYC - 1);
endmodule : tas_step_timer

// ===== logic/tas_sequencer.sv
// module: tracking converter sequencer top
// Operation
// RQ1 - step pulses only after start pulse
// RQ2 - each step moves wiper one position
// RQ3 - comparator output selects step direction
// RQ4 - stop after third comparator rising edge
// RQ5 - no reload: continue from previous code
// RQ6 - reload: preload default code before stepping
// RQ7 - result is final wiper code
// RQ8 - step clock at most 1 kHz
// RQ9 - done held, code stable until start
`timescale 1ns/10ps
module tas_sequencer #(
  parameter int unsigned CLK_HZ          = tas_pkg::CLK_HZ,
  parameter int unsigned STEP_PERIOD_CYC = tas_pkg::STEP_PERIOD_CYC
) (
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  input  wire logic                       startPulse,
  input  wire logic                       autoReloadEn,
  input  wire logic [tas_pkg::CODE_W-1:0] defaultCode,
  input  wire logic                       comparator_output,
  output logic                            stepClk,
  output logic                            stepUp,
  output logic [tas_pkg::CODE_W-1:0]      wiperCode,
  output tas_pkg::tas_result_t            result
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks

  // shortest step period that keeps the wiper clock within its rate limit
  localparam int unsigned MinPeriodCyc =
    (CLK_HZ + tas_pkg::STEP_MAX_HZ - 1) / tas_pkg::STEP_MAX_HZ;

  if (STEP_PERIOD_CYC < MinPeriodCyc) begin : g_rate_check
    $error("step period gives a wiper clock above its rate limit");
  end

  if (STEP_PERIOD_CYC < 2) begin : g_period_check
    $error("step period too short for the step timer");
  end

  if (tas_pkg::EDGE_LIMIT < 1 || tas_pkg::EDGE_LIMIT > 2 ** tas_pkg::EDGE_W) begin : g_edge_check
    $error("edge limit does not fit the edge counter");
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // true when this rise is the one that ends the conversion
  function automatic logic isFinalRise(
    input logic                       rise,
    input logic [tas_pkg::EDGE_W-1:0] count
  );
    isFinalRise = rise && (count == tas_pkg::EDGE_W'(tas_pkg::EDGE_LIMIT - 1));
  endfunction : isFinalRise

  // one position toward the input, held at either end of the range
  function automatic logic [tas_pkg::CODE_W-1:0] nextCode(
    input logic [tas_pkg::CODE_W-1:0] code,
    input logic                       up
  );
    logic [tas_pkg::CODE_W-1:0] next;
    next = code;
    if (up && code != {tas_pkg::CODE_W{1'b1}}) begin
      next = code + tas_pkg::CODE_W'(1);
    end else if (!up && code != '0) begin
      next = code - tas_pkg::CODE_W'(1);
    end
    nextCode = next;
  endfunction : nextCode

  ////////////////////////////////////////////////////////////////////////////
  // state and helper signals

  tas_pkg::tas_state_t                state_q;
  logic [tas_pkg::CODE_W-1:0]         code_q;
  logic [tas_pkg::EDGE_W-1:0]         edges_q;
  logic                               cmpPrev_q;
  logic                               stepClk_q;
  logic                               tick;
  logic                               cmpRise;
  logic                               tracking;
  logic                               loading;
  logic                               finalRise;
  logic                               stepTaken;

  assign tracking  = (state_q == tas_pkg::ST_TRACK);
  assign loading   = (state_q == tas_pkg::ST_LOAD);
  assign cmpRise   = comparator_output && !cmpPrev_q;
  assign finalRise = tracking && isFinalRise(cmpRise, edges_q); // RQ4

  // a step is only taken when the wiper can really move, so every pulse
  // on the wiper clock matches exactly one position of travel
  assign stepTaken = tracking && tick && !finalRise &&
                     (nextCode(code_q, comparator_output) != code_q); // RQ2

  ////////////////////////////////////////////////////////////////////////////
  // step rate timer

  tas_step_timer #(
    .PERIOD_CYC (STEP_PERIOD_CYC)
  ) u_timer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .run     (tracking),
    .tick    (tick)
  ); // RQ8

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequence

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= tas_pkg::ST_IDLE;
    end else begin
      case (state_q)
        tas_pkg::ST_IDLE,
        tas_pkg::ST_DONE: begin
          if (startPulse) begin
            state_q <= tas_pkg::ST_LOAD; // RQ1
          end
        end
        tas_pkg::ST_LOAD: begin
          state_q <= tas_pkg::ST_TRACK;
        end
        tas_pkg::ST_TRACK: begin
          if (finalRise) begin
            state_q <= tas_pkg::ST_DONE; // RQ4
          end
        end
        default: begin
          state_q <= tas_pkg::ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // comparator edge detection

  // the load cycle primes the previous level high, so a comparator that
  // is already high when tracking begins, or that moved because of a
  // preload, is not taken as a rise
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cmpPrev_q <= 1'b1;
    end else if (loading) begin
      cmpPrev_q <= 1'b1;
    end else begin
      cmpPrev_q <= comparator_output;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      edges_q <= '0;
    end else if (loading) begin
      edges_q <= '0;
    end else if (tracking && cmpRise) begin
      edges_q <= edges_q + tas_pkg::EDGE_W'(1); // RQ4
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wiper code

  // comparator high means wiper is below input, so step up
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      code_q <= tas_pkg::CODE_RESET;
    end else if (loading && autoReloadEn) begin
      code_q <= defaultCode; // RQ6
    end else if (stepTaken) begin
      code_q <= nextCode(code_q, comparator_output); // RQ2 RQ3
    end
    // without reload the load state leaves code_q untouched  RQ5
  end

  ////////////////////////////////////////////////////////////////////////////
  // wiper clock

  // pulse comes in the same cycle as the code change; none outside tracking
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stepClk_q <= 1'b0;
    end else begin
      stepClk_q <= stepTaken; // RQ1 RQ4 RQ8
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign stepClk   = stepClk_q;
  assign stepUp    = comparator_output; // RQ3
  assign wiperCode = code_q;            // RQ9

  always_comb begin
    result.code = code_q;                        // RQ7
    result.done = (state_q == tas_pkg::ST_DONE); // RQ9
    result.busy = loading || tracking;
  end

endmodule : tas_sequencer

// ===== tb/tas_cmp_model.sv
// partner: comparator of wiper level against input level
`timescale 1ns/10ps
module tas_cmp_model (
  input  wire logic [9:0] wiperCode,
  input  wire logic [9:0] vin,
  output logic            comparator_output
);
  assign comparator_output = wiperCode < vin;
endmodule : tas_cmp_model

// ===== tb/tas_sequencer_chk.sv
// checker: port properties of the sequencer
`timescale 1ns/10ps
module tas_sequencer_chk #(
  parameter int unsigned STEP_PERIOD_CYC = 4
) (
  input wire logic                 ref_clk,
  input wire logic                 rst,
  input wire logic                 startPulse,
  input wire logic                 autoReloadEn,
  input wire logic [9:0]           defaultCode,
  input wire logic                 comparator_output,
  input wire logic                 stepClk,
  input wire logic                 stepUp,
  input wire logic [9:0]           wiperCode,
  input wire tas_pkg::tas_result_t result
);
  // the rate property counts three idle cycles after each pulse
  if (STEP_PERIOD_CYC < 4) begin : g_period_check
    $error("checker needs a step period of at least four cycles");
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_start; $rose(result.busy) |-> $past(startPulse); endproperty
  a_start: assert property (p_start) else $error("start");
  property p_gate; stepClk |-> $past(result.busy); endproperty
  a_gate: assert property (p_gate) else $error("gate");
  property p_step; result.busy && $changed(wiperCode) && $past(result.busy, 2) |->
    wiperCode == $past(wiperCode) + ($past(comparator_output) ? 1 : -1); endproperty
  a_step: assert property (p_step) else $error("step");
  property p_keep; $rose(result.busy) && !autoReloadEn |=> wiperCode == $past(wiperCode, 2);
  endproperty
  a_keep: assert property (p_keep) else $error("keep");
  property p_load; $rose(result.busy) && autoReloadEn |=> wiperCode == $past(defaultCode);
  endproperty
  a_load: assert property (p_load) else $error("load");
  property p_res; result.code == wiperCode; endproperty
  a_res: assert property (p_res) else $error("result");
  property p_rate; stepClk |=> !stepClk [*3]; endproperty
  a_rate: assert property (p_rate) else $error("rate");
  property p_hold; result.done && !startPulse |=> result.done && $stable(wiperCode); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  sequence s_accept; startPulse && !result.busy; endsequence
  sequence s_loaded; result.busy && !result.done; endsequence
  property p_launch; s_accept |=> s_loaded; endproperty
  a_launch: assert property (p_launch) else $error("launch");
  property p_idle; result.done |-> !stepClk; endproperty
  a_idle: assert property (p_idle) else $error("idle");
endmodule : tas_sequencer_chk
bind tas_sequencer tas_sequencer_chk #(.STEP_PERIOD_CYC(STEP_PERIOD_CYC)) chk (
  .ref_clk(ref_clk), .rst(rst), .startPulse(startPulse), .autoReloadEn(autoReloadEn),
  .defaultCode(defaultCode), .comparator_output(comparator_output), .stepClk(stepClk),
  .stepUp(stepUp), .wiperCode(wiperCode), .result(result));

// ===== tb/test_tracking_adc_sequencer.sv
// testbench: sequencer against an integer tracking model
`timescale 1ns/10ps
module test_tracking_adc_sequencer;
  logic ref_clk = 0, rst = 1, startPulse = 0, autoReloadEn = 0, cmp, stepClk, stepUp;
  logic [9:0] defaultCode = 0, vin = 1, wiperCode;
  tas_pkg::tas_result_t result;
  int fail_count = 0, check_count = 0, cur = tas_pkg::CODE_RESET, n, up, prev;
  int steps = 0, msteps = 0;
  // a scaled clock figure lets a four-cycle step period pass the rate check
  tas_sequencer #(.CLK_HZ(4000), .STEP_PERIOD_CYC(4)) dut (.ref_clk, .rst, .startPulse,
    .autoReloadEn, .defaultCode, .comparator_output(cmp), .stepClk, .stepUp, .wiperCode,
    .result);
  tas_cmp_model model (.wiperCode, .vin, .comparator_output(cmp));
  initial forever #4 ref_clk = !ref_clk;
  always @(posedge ref_clk) if (stepClk === 1'b1) steps++;
  task report_and_stop;
    $display("checks %0d fails %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  initial begin
    #480000 fail_count++;
    report_and_stop;
  end
  initial begin
    void'($urandom(32'h219b));
    repeat (20) @(posedge ref_clk);
    rst <= 0;
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      vin <= i == 0 ? 10'h3ff : i == 1 ? 10'h1 : 10'($urandom_range(1023, 1));
      defaultCode <= 10'($urandom);
      autoReloadEn <= i[0];
      startPulse <= 1;
      steps = 0;
      // start held into the load cycle, where it must be ignored
      repeat (2) @(posedge ref_clk);
      startPulse <= 0;
      if (autoReloadEn) cur = defaultCode;
      prev = cur < vin;
      msteps = 0;
      for (n = 0; n < 3; prev = up) begin
        cur += cur < vin ? 1 : -1;
        msteps++;
        up = cur < vin;
        n += up && !prev;
      end
      for (int k = 0; k < 5000 && result.done !== 1; k++) @(posedge ref_clk);
      repeat (9) @(posedge ref_clk);
      check_count++;
      if (result !== {10'(cur), 2'b10}) begin
        fail_count++;
        $display("CHECK FAILED %0t code %h", $time, result.code);
      end
      check_count++;
      if (steps !== msteps) begin
        fail_count++;
        $display("CHECK FAILED %0t step pulses %0d", $time, steps);
      end
      check_count++;
      if (stepUp !== cmp) begin
        fail_count++;
        $display("CHECK FAILED %0t direction", $time);
      end
      $display("test %0d done", i);
    end
    $display("tracking tests done");
    report_and_stop;
  end
endmodule : test_tracking_adc_sequencer
